// ---- include/charger_pkg.sv ----
// constants shared by the input current limit register and the power source selector
`default_nettype none
package charger_pkg;
	localparam int          CLK_PERIOD_NS     = 25;    // 40 MHz system clock
	localparam logic [7:0]  CMD_INPUT_LIMIT   = 8'h3F; // command code of the limit word
	localparam logic [15:0] INPUT_LIMIT_RESET = 16'h1000; // 4096 mA at power-on
	localparam logic [15:0] INPUT_LIMIT_CLEAR = 16'h0000;
	localparam int          LIMIT_CODE_LSB    = 7;     // code weight 128 mA
	localparam int          LIMIT_CODE_MSB    = 12;    // code weight 4096 mA
	localparam int          LIMIT_CODE_W      = 6;
	localparam logic [5:0]  LIMIT_CODE_ZERO   = 6'h00;
	localparam logic [3:0]  BITS_PER_BYTE     = 4'h8;
	localparam logic [2:0]  BIT_MSB_IDX       = 3'h7;
	// break-before-make dead time, rounded up to whole clock cycles
	localparam int          BBM_DEAD_NS       = 500;
	localparam int          BBM_DEAD_CYC_I    = (BBM_DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0]  BBM_DEAD_CYC      = 6'(BBM_DEAD_CYC_I);
	localparam logic [5:0]  BBM_CNT_ZERO      = 6'h00;
	localparam logic [5:0]  BBM_CNT_ONE       = 6'h01;
endpackage : charger_pkg
`default_nettype wire

// ---- include/source_sel_if.sv ----
// signals between the register block and the power source selector
`timescale 1ns/1ps
`default_nettype none
interface source_sel_if;
	logic adapter_ok;  // debounced adapter presence
	logic adapter_on;  // adapter and reverse block switches closed
	logic battery_on;  // battery switch closed
	modport ctrl (output adapter_ok, input adapter_on, input battery_on);
	modport sel  (input adapter_ok, output adapter_on, output battery_on);
endinterface : source_sel_if
`default_nettype wire

// ---- rtl/source_selector.sv ----
// automatic adapter / battery source selection with break-before-make
`timescale 1ns/1ps
`default_nettype none
module source_selector
	import charger_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  reset_i,
	source_sel_if.sel  sel_if
);
	typedef enum logic [1:0] {SEL_OFF, SEL_ADP, SEL_BAT} sel_state_t;

	sel_state_t state_r;
	sel_state_t state_nxt;
	logic [5:0] dead_cnt_r;
	logic [5:0] dead_cnt_nxt;
	logic       dead_done;

	// both switches open until the dead time has run out
	assign dead_done = (dead_cnt_r == BBM_DEAD_CYC);

	// no host command is involved: presence alone picks the source
	always_comb begin
		state_nxt    = state_r;
		dead_cnt_nxt = dead_cnt_r;
		case (state_r)
			SEL_OFF: begin
				if (dead_done) begin
					state_nxt = sel_if.adapter_ok ? SEL_ADP : SEL_BAT;
				end else begin
					dead_cnt_nxt = dead_cnt_r + BBM_CNT_ONE;
				end
			end
			SEL_ADP: begin
				if (!sel_if.adapter_ok) begin
					state_nxt    = SEL_OFF;
					dead_cnt_nxt = BBM_CNT_ZERO;
				end
			end
			default: begin
				if (sel_if.adapter_ok) begin
					state_nxt    = SEL_OFF;
					dead_cnt_nxt = BBM_CNT_ZERO;
				end
			end
		endcase
	end

	// switch drives follow the next state, so both open in the same edge
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_r           <= SEL_OFF;
			dead_cnt_r        <= BBM_CNT_ZERO;
			sel_if.adapter_on <= 1'b0;
			sel_if.battery_on <= 1'b0;
		end else begin
			state_r           <= state_nxt;
			dead_cnt_r        <= dead_cnt_nxt;
			sel_if.adapter_on <= (state_nxt == SEL_ADP);
			sel_if.battery_on <= (state_nxt == SEL_BAT);
		end
	end
endmodule : source_selector
`default_nettype wire

// ---- rtl/input_current_limit_register.sv ----
// charger input current limit register behind an SMBus word slave, with source selector
//
// Notes on behaviour
// - the host sets the input current limit only by writing this register over SMBus.
// - the limit word is reached through command code 0x3F, sixteen bits wide.
// - bits 12..7 are a binary code, 128 mA per step up to 4096 mA weight.
// - all sixteen bits read back exactly as written, unused ones included, unless the written code is zero.
// - adapter or battery is picked automatically as system source, no command needed.
// - the old source switch opens before the new one closes.
// - a code below 128 mA clears the register and stops charging.
// - after reset the limit is 4096 mA until the host writes.
`timescale 1ns/1ps
`default_nettype none
module input_current_limit_register
	import charger_pkg::*;
#(
	parameter logic [6:0] DEVICE_ADDR = 7'h12 // bus address, value arbitrary
) (
	input  wire logic       CLK_SYS_I,
	input  wire logic       RESET_I,
	input  wire logic       SCL_I,
	input  wire logic       SDA_I,
	output var  logic       SDA_O,
	output var  logic       SDA_OE_N_O,
	input  wire logic       ADAPTER_PRESENT_I,
	output var  logic [5:0] INPUT_LIMIT_CODE_O,
	output var  logic       CHARGE_ENABLE_O,
	output var  logic       ADAPTER_PATH_SWITCH_O,
	output var  logic       REVERSE_BLOCK_SWITCH_O,
	output var  logic       BATTERY_PATH_SWITCH_O
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_CMD, ST_WLO, ST_WHI, ST_RLO, ST_RHI, ST_SKIP
	} bus_state_t;

	// three-stage synchronisers; a level is accepted when stages two and three agree
	logic [2:0] scl_sync_r;
	logic [2:0] sda_sync_r;
	logic [2:0] adp_sync_r;
	logic       scl_f_r;
	logic       sda_f_r;
	logic       adp_f_r;

	bus_state_t  state_r;
	logic        ack_phase_r;
	logic [3:0]  bit_cnt_r;
	logic [7:0]  shift_r;
	logic [7:0]  wlo_r;
	logic        cmd_ok_r;
	logic        master_nack_r;
	logic [15:0] input_current_limit_r;

	source_sel_if sel_bus ();

	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			scl_sync_r <= 3'h7;
			sda_sync_r <= 3'h7;
			adp_sync_r <= 3'h0;
			scl_f_r    <= 1'b1;
			sda_f_r    <= 1'b1;
			adp_f_r    <= 1'b0;
		end else begin
			scl_sync_r <= {scl_sync_r[1:0], SCL_I};
			sda_sync_r <= {sda_sync_r[1:0], SDA_I};
			adp_sync_r <= {adp_sync_r[1:0], ADAPTER_PRESENT_I};
			if (scl_sync_r[1] == scl_sync_r[2]) scl_f_r <= scl_sync_r[2];
			if (sda_sync_r[1] == sda_sync_r[2]) sda_f_r <= sda_sync_r[2];
			if (adp_sync_r[1] == adp_sync_r[2]) adp_f_r <= adp_sync_r[2];
		end
	end

	// bus conditions from the filtered levels
	logic scl_new;
	logic sda_new;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	assign scl_new    = (scl_sync_r[1] == scl_sync_r[2]) ? scl_sync_r[2] : scl_f_r;
	assign sda_new    = (sda_sync_r[1] == sda_sync_r[2]) ? sda_sync_r[2] : sda_f_r;
	assign scl_rise   = !scl_f_r && scl_new;
	assign scl_fall   = scl_f_r && !scl_new;
	assign start_cond = scl_f_r && scl_new && sda_f_r && !sda_new;
	assign stop_cond  = scl_f_r && scl_new && !sda_f_r && sda_new;

	// byte decode at the eighth clock fall; only our address and command are acknowledged
	logic        byte_done;
	logic        addr_match;
	logic        cmd_match;
	logic        sending;
	logic [7:0]  tx_byte;
	logic [2:0]  tx_idx;
	logic [15:0] wr_word;
	logic        wr_code_zero;
	assign byte_done    = (bit_cnt_r == BITS_PER_BYTE);
	assign addr_match   = (shift_r[7:1] == DEVICE_ADDR);
	assign cmd_match    = (shift_r == CMD_INPUT_LIMIT);
	assign sending      = (state_r == ST_RLO) || (state_r == ST_RHI);
	assign tx_byte      = (state_r == ST_RHI) ? input_current_limit_r[15:8]
		: input_current_limit_r[7:0];
	assign tx_idx       = BIT_MSB_IDX - bit_cnt_r[2:0];
	assign wr_word      = {shift_r, wlo_r};
	assign wr_code_zero = (wr_word[LIMIT_CODE_MSB:LIMIT_CODE_LSB] == LIMIT_CODE_ZERO);

	// protocol engine; the data line is only ever pulled low, never driven high
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			state_r       <= ST_IDLE;
			ack_phase_r   <= 1'b0;
			bit_cnt_r     <= 4'h0;
			shift_r       <= 8'h00;
			wlo_r         <= 8'h00;
			cmd_ok_r      <= 1'b0;
			master_nack_r <= 1'b0;
			input_current_limit_r <= INPUT_LIMIT_RESET;
			SDA_OE_N_O    <= 1'b1;
		end else if (start_cond) begin
			// a repeated start keeps the command for the read that follows
			state_r     <= ST_ADDR;
			ack_phase_r <= 1'b0;
			bit_cnt_r   <= 4'h0;
			SDA_OE_N_O  <= 1'b1;
		end else if (stop_cond) begin
			state_r     <= ST_IDLE;
			ack_phase_r <= 1'b0;
			cmd_ok_r    <= 1'b0;
			SDA_OE_N_O  <= 1'b1;
		end else if (scl_rise && state_r != ST_IDLE) begin
			if (ack_phase_r) begin
				master_nack_r <= sda_new;
			end else if (!byte_done) begin
				shift_r   <= {shift_r[6:0], sda_new};
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end
		end else if (scl_fall && state_r != ST_IDLE) begin
			if (!ack_phase_r && byte_done) begin
				ack_phase_r <= 1'b1;
				bit_cnt_r   <= 4'h0;
				SDA_OE_N_O  <= 1'b1;
				case (state_r)
					ST_ADDR: begin
						if (addr_match && !shift_r[0]) begin
							state_r    <= ST_CMD;
							SDA_OE_N_O <= 1'b0;
						end else if (addr_match && cmd_ok_r) begin
							state_r    <= ST_RLO;
							SDA_OE_N_O <= 1'b0;
						end else begin
							state_r <= ST_SKIP;
						end
					end
					ST_CMD: begin
						cmd_ok_r   <= cmd_match;
						state_r    <= cmd_match ? ST_WLO : ST_SKIP;
						SDA_OE_N_O <= !cmd_match;
					end
					ST_WLO: begin
						wlo_r      <= shift_r;
						state_r    <= ST_WHI;
						SDA_OE_N_O <= 1'b0;
					end
					ST_WHI: begin
						// unused bits are kept as written; a zero code wipes the word
						input_current_limit_r <= wr_code_zero ? INPUT_LIMIT_CLEAR : wr_word;
						state_r    <= ST_SKIP;
						SDA_OE_N_O <= 1'b0;
					end
					ST_RLO:  state_r <= ST_RHI; // master acks the low byte
					default: state_r <= ST_SKIP;
				endcase
			end else if (ack_phase_r) begin
				// end of the acknowledge bit: release, or put out the next msb
				ack_phase_r <= 1'b0;
				if (state_r == ST_RLO) begin
					SDA_OE_N_O <= tx_byte[BIT_MSB_IDX];
				end else if (state_r == ST_RHI && !master_nack_r) begin
					SDA_OE_N_O <= tx_byte[BIT_MSB_IDX];
				end else begin
					if (state_r == ST_RHI) state_r <= ST_SKIP;
					SDA_OE_N_O <= 1'b1;
				end
			end else if (sending) begin
				SDA_OE_N_O <= tx_byte[tx_idx];
			end
		end
	end

	// only the code field reaches the regulator; the other bits are only read back
	logic [LIMIT_CODE_W-1:0] input_limit_code;
	assign input_limit_code   = input_current_limit_r[LIMIT_CODE_MSB:LIMIT_CODE_LSB];
	assign sel_bus.adapter_ok = adp_f_r;

	source_selector u_source_selector (
		.clk_i   (CLK_SYS_I),
		.reset_i (RESET_I),
		.sel_if  (sel_bus)
	);

	// output flops; both adapter-side switches move together
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			SDA_O                  <= 1'b0;
			INPUT_LIMIT_CODE_O     <= INPUT_LIMIT_RESET[LIMIT_CODE_MSB:LIMIT_CODE_LSB];
			CHARGE_ENABLE_O        <= 1'b0;
			ADAPTER_PATH_SWITCH_O  <= 1'b0;
			REVERSE_BLOCK_SWITCH_O <= 1'b0;
			BATTERY_PATH_SWITCH_O  <= 1'b0;
		end else begin
			SDA_O                  <= 1'b0;
			INPUT_LIMIT_CODE_O     <= input_limit_code;
			CHARGE_ENABLE_O        <= (input_limit_code != LIMIT_CODE_ZERO);
			ADAPTER_PATH_SWITCH_O  <= sel_bus.adapter_on;
			REVERSE_BLOCK_SWITCH_O <= sel_bus.adapter_on;
			BATTERY_PATH_SWITCH_O  <= sel_bus.battery_on;
		end
	end
endmodule : input_current_limit_register
`default_nettype wire

// ---- sim/input_current_limit_register_properties.sv ----
// port-level checks for the input current limit register block
`timescale 1ns/1ps
`default_nettype none
module limit_reg_checker (
	input wire logic       CLK_SYS_I,
	input wire logic       RESET_I,
	input wire logic       SDA_O,
	input wire logic       SDA_OE_N_O,
	input wire logic [5:0] INPUT_LIMIT_CODE_O,
	input wire logic       CHARGE_ENABLE_O,
	input wire logic       ADAPTER_PATH_SWITCH_O,
	input wire logic       REVERSE_BLOCK_SWITCH_O,
	input wire logic       BATTERY_PATH_SWITCH_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RESET_I);
	// pin relations; dead time checked by looking back exactly 20 cycles
	a_tx_open_drain: assert property (SDA_O == 1'b0) else $error("data pin high");
	a_reset_values: assert property ($fell(RESET_I) |-> INPUT_LIMIT_CODE_O == 6'h20
		&& !ADAPTER_PATH_SWITCH_O && !BATTERY_PATH_SWITCH_O) else $error("reset values");
	a_charge_code: assert property (!$past(RESET_I) |->
		CHARGE_ENABLE_O == (INPUT_LIMIT_CODE_O != 6'h00)) else $error("charge vs code");
	a_code_on_ack: assert property ($changed(INPUT_LIMIT_CODE_O) |-> !SDA_OE_N_O)
		else $error("code moved without write");
	a_switch_excl: assert property (!(ADAPTER_PATH_SWITCH_O && BATTERY_PATH_SWITCH_O))
		else $error("both switches closed");
	a_reverse_same: assert property (REVERSE_BLOCK_SWITCH_O == ADAPTER_PATH_SWITCH_O)
		else $error("reverse switch differs");
	a_bat_dead: assert property ($rose(BATTERY_PATH_SWITCH_O) |->
		!$past(ADAPTER_PATH_SWITCH_O, 20)) else $error("battery dead time short");
	a_adp_dead: assert property ($rose(ADAPTER_PATH_SWITCH_O) |->
		!$past(BATTERY_PATH_SWITCH_O, 20)) else $error("adapter dead time short");
endmodule : limit_reg_checker
bind input_current_limit_register limit_reg_checker chk_i (.CLK_SYS_I(CLK_SYS_I),
	.RESET_I(RESET_I), .SDA_O(SDA_O), .SDA_OE_N_O(SDA_OE_N_O),
	.INPUT_LIMIT_CODE_O(INPUT_LIMIT_CODE_O), .CHARGE_ENABLE_O(CHARGE_ENABLE_O),
	.ADAPTER_PATH_SWITCH_O(ADAPTER_PATH_SWITCH_O),
	.REVERSE_BLOCK_SWITCH_O(REVERSE_BLOCK_SWITCH_O),
	.BATTERY_PATH_SWITCH_O(BATTERY_PATH_SWITCH_O));
`default_nettype wire

// ---- sim/smbus_host_model.sv ----
// power management host: bit-level SMBus master on an open-drain data line
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model #(
	parameter logic [6:0] ADDR = 7'h12, // bus address, value arbitrary
	parameter int         HALF = 10     // clocks per SCL phase, sync needs 8
) (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output var  logic scl_o,
	output var  logic sda_pull_o
);
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	// pins move only on falling edges, away from the sampling edge
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask : tick
	// data set while SCL low, read at the end of the high phase
	task automatic bit_x(input logic b, output logic r);
		scl_o = 1'b0;
		tick(3);
		sda_pull_o = !b;
		tick(HALF);
		scl_o = 1'b1;
		tick(HALF);
		r = sda_i;
	endtask : bit_x
	// start (lo 0) or stop (lo 1): data moves while SCL high
	task automatic frame(input logic lo);
		scl_o = 1'b0;
		tick(3);
		sda_pull_o = lo;
		tick(HALF);
		scl_o = 1'b1;
		tick(HALF);
		sda_pull_o = !lo;
		tick(HALF);
	endtask : frame
	task automatic byte_x(input logic [7:0] tx, input logic nak, output logic [7:0] rx,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(tx[i], r);
			rx[i] = r;
		end
		bit_x(nak, r);
		ack = !r;
	endtask : byte_x
	// word write, or word read through a repeated start; low byte first
	task automatic xact(input logic rd, input logic [7:0] cmd, input logic [15:0] w,
		output logic [15:0] r, output logic ok);
		logic [7:0] b;
		logic       a0, a1, a2, a3;
		frame(1'b0);
		byte_x({ADDR, 1'b0}, 1'b1, b, a0);
		byte_x(cmd, 1'b1, b, a1);
		if (rd) begin
			frame(1'b0);
			byte_x({ADDR, 1'b1}, 1'b1, b, a2);
			byte_x(8'hFF, 1'b0, r[7:0], a3);
			byte_x(8'hFF, 1'b1, r[15:8], a3);
		end else begin
			byte_x(w[7:0], 1'b1, b, a2);
			byte_x(w[15:8], 1'b1, b, a3);
		end
		frame(1'b1);
		ok = a0 && a1 && a2 && (rd || a3);
	endtask : xact
endmodule : smbus_host_model
`default_nettype wire

// ---- sim/input_current_limit_register_tb.sv ----
// self-checking bench for the input current limit register
`timescale 1ns/1ps
`default_nettype none
module input_current_limit_register_tb
	import charger_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        adp = 1'b0;
	logic [5:0]  code;
	logic        chg, acs, rbs, bas, sda_o, oe_n, ok;
	logic [15:0] rd;
	wire logic   scl, pull;
	wire logic   sda = !pull && (oe_n || sda_o); // pull-up when nobody pulls low
	int          miscompares = 0;
	int          total_checks = 0;
	logic [15:0] words [4] = '{16'hFFFF, 16'h0080, 16'h6F80, 16'h1F7F};
	always #(CLK_PERIOD_NS / 2.0) clk = !clk;
	input_current_limit_register dut (.CLK_SYS_I(clk), .RESET_I(rst), .SCL_I(scl), .SDA_I(sda),
		.SDA_O(sda_o), .SDA_OE_N_O(oe_n), .ADAPTER_PRESENT_I(adp), .INPUT_LIMIT_CODE_O(code),
		.CHARGE_ENABLE_O(chg), .ADAPTER_PATH_SWITCH_O(acs), .REVERSE_BLOCK_SWITCH_O(rbs),
		.BATTERY_PATH_SWITCH_O(bas));
	smbus_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict
	// bounded wait for a switch; sync plus dead time is well under 40 cycles
	task automatic wait_sw(input logic want_adp);
		int n;
		n = 0;
		while ((want_adp ? acs : bas) !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (n == 40) begin
			miscompares++;
			print_verdict();
		end
	endtask : wait_sw
	task automatic t_power_on;
		chk(code, INPUT_LIMIT_RESET[12:7]);
		chk(chg, 1'b1);
		host.xact(1'b1, CMD_INPUT_LIMIT, 16'h0000, rd, ok);
		chk(ok, 1'b1);
		chk(rd, INPUT_LIMIT_RESET);
		$display("test power_on done");
	endtask : t_power_on
	// extremes of the code plus unused bits set and cleared
	task automatic t_writes;
		foreach (words[i]) begin
			host.xact(1'b0, CMD_INPUT_LIMIT, words[i], rd, ok);
			chk(ok, 1'b1);
			chk(code, words[i][12:7]);
			chk(chg, 1'b1);
			host.xact(1'b1, CMD_INPUT_LIMIT, 16'h0000, rd, ok);
			chk(rd, words[i]);
		end
		$display("test writes done");
	endtask : t_writes
	// a word to another command must leave the limit alone; a read without it is refused
	task automatic t_other_cmd;
		host.xact(1'b0, 8'h15, 16'hFFFF, rd, ok);
		chk(ok, 1'b0);
		chk(code, words[3][12:7]);
		host.xact(1'b1, 8'h15, 16'h0000, rd, ok);
		chk(ok, 1'b0);
		chk(rd, 16'hFFFF);
		host.xact(1'b1, CMD_INPUT_LIMIT, 16'h0000, rd, ok);
		chk(rd, words[3]);
		$display("test other_cmd done");
	endtask : t_other_cmd
	// zero code with every unused bit set clears the whole word
	task automatic t_clear;
		host.xact(1'b0, CMD_INPUT_LIMIT, 16'hE07F, rd, ok);
		chk(ok, 1'b1);
		chk(code, 16'h0000);
		chk(chg, 1'b0);
		host.xact(1'b1, CMD_INPUT_LIMIT, 16'h0000, rd, ok);
		chk(rd, 16'h0000);
		$display("test clear done");
	endtask : t_clear
	task automatic t_source;
		chk({acs, rbs, bas}, 3'b001);
		adp = 1'b1;
		wait_sw(1'b1);
		chk({acs, rbs, bas}, 3'b110);
		adp = 1'b0;
		wait_sw(1'b0);
		chk({acs, rbs, bas}, 3'b001);
		$display("test source done");
	endtask : t_source
	// a second reset in mid-run restores the default limit and reopens both paths
	task automatic t_reset;
		rst = 1'b1;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chk(code, INPUT_LIMIT_RESET[12:7]);
		chk(chg, 1'b1);
		chk({acs, rbs, bas}, 3'h0);
		host.xact(1'b1, CMD_INPUT_LIMIT, 16'h0000, rd, ok);
		chk(rd, INPUT_LIMIT_RESET);
		chk({acs, rbs, bas}, 3'h1);
		$display("test reset done");
	endtask : t_reset
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		t_power_on();
		t_writes();
		t_other_cmd();
		t_clear();
		t_source();
		t_reset();
		print_verdict();
	end
endmodule : input_current_limit_register_tb
`default_nettype wire
